//--- core/nv_access_ctrl.sv
// Nonvolatile data memory access controller behind the special-function register port.
//
// Operation
// RULE1: Sixty-four byte array, reached one byte at a time via address and data registers.
// RULE2: Address register holds six bits, upper two read zero, resets to zero.
// RULE3: Data register is eight bits read/write, cleared at power-on.
// RULE4: Control register sits at 40H of bank 1, reached through pointer one.
// RULE5: Address and data registers are directly reachable regardless of bank.
// RULE6: Write permit bit 3 must be high; when low writes are inhibited.
// RULE7: Setting program trigger bit 2 starts a write of data at address.
// RULE8: Hardware clears program trigger when the write cycle completes.
// RULE9: Program trigger set without prior write permit starts nothing.
// RULE10: Read permit bit 1 needed; read trigger without it starts nothing.
// RULE11: Read trigger bit 0 with read permit starts a read at address.
// RULE12: Read trigger clears at read end; fetched byte then valid in data.
// RULE13: Data register holds fetched byte until next read or write.
// RULE14: Software raises read permit, loads address, then sets read trigger.
// RULE15: Software polls read trigger before fetching the data register.
// RULE16: Software never sets both triggers, nor enable with trigger together.
// RULE17: Control upper four bits read zero; four used bits reset to zero.
// RULE18: Software sets write trigger right after write permit, interrupts masked.
// RULE19: Every completed write sets the done flag; servicing clears it.
// RULE20: Software avoids idle or sleep until an access has completed.
// RULE21: Write cycle length is a timer count; triggers ignored meanwhile.
// RULE22: A trigger arriving during a running cycle is ignored.
`include "nv_access_map.svh"
`default_nettype none
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       IRQ_ACK_I,
  output logic      [7:0] SFR_RDATA_O,
  output logic            SFR_HIT_O,
  output logic            NV_DONE_FLAG_O,
  output logic            NV_BUSY_O
);

  sfr_access_type acc;
  assign acc = '{wr: SFR_WR_I, rd: SFR_RD_I, addr: SFR_ADDR_I, wdata: SFR_WDATA_I};

  logic [7:0] nv_array [0:`NV_DEPTH-1];
  logic [`NV_ADDR_WIDTH-1:0] nv_address_reg;
  logic [7:0] nv_data_reg;
  logic [7:0] indirect_pointer_one;
  logic       bank_selector;
  logic       program_permit;
  logic       program_trigger;
  logic       read_permit;
  logic       read_trigger;
  nv_state_type state;
  logic [15:0]  timer;

  // The control register is not directly addressable, so a stray direct write cannot arm it.
  logic ctrl_sel;
  logic ctrl_wr;
  logic [7:0] ctrl_value;
  logic [7:0] next_rdata;
  logic       next_hit;
  logic       start_write;
  logic       start_read;
  logic       write_end;
  logic       read_end;

  assign ctrl_sel = (acc.addr == `INDIRECT_ONE_OFFSET) && bank_selector
                    && (indirect_pointer_one == `NV_CONTROL_OFFSET); // see RULE4
  assign ctrl_wr = acc.wr && ctrl_sel;
  assign ctrl_value = {4'h0, program_permit, program_trigger, read_permit, read_trigger}; // see RULE17
  // Permit must already be high before this write: sampled from the register, not the bus.
  assign start_write = ctrl_wr && acc.wdata[`CTRL_PROG_TRIGGER] && program_permit
                       && (state == IDLE_ST); // see RULE6 see RULE9 see RULE22
  assign start_read = ctrl_wr && acc.wdata[`CTRL_READ_TRIGGER] && read_permit
                      && !acc.wdata[`CTRL_PROG_TRIGGER] && (state == IDLE_ST); // see RULE10 see RULE22
  assign write_end = (state == WRITE_ST) && (timer == 16'h0000);
  assign read_end = (state == READ_ST) && (timer == 16'h0000);

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      indirect_pointer_one <= 8'h00;
      bank_selector <= 1'b0;
    end else if (acc.wr) begin
      if (acc.addr == `POINTER_ONE_OFFSET) begin
        indirect_pointer_one <= acc.wdata;
      end
      if (acc.addr == `BANK_SEL_OFFSET) begin
        bank_selector <= acc.wdata[`BANK_SEL_BIT];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nv_address_reg <= '0; // see RULE2
    end else if (acc.wr && acc.addr == `NV_ADDRESS_OFFSET) begin
      nv_address_reg <= acc.wdata[`NV_ADDR_WIDTH-1:0]; // see RULE5
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      program_permit <= 1'b0;
      read_permit <= 1'b0;
    end else if (ctrl_wr) begin
      program_permit <= acc.wdata[`CTRL_PROG_PERMIT];
      read_permit <= acc.wdata[`CTRL_READ_PERMIT];
    end
  end

  // Triggers can only be raised by hardware start; software writing zero cannot abort a cycle.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      program_trigger <= 1'b0;
      read_trigger <= 1'b0;
    end else begin
      if (start_write) begin
        program_trigger <= 1'b1; // see RULE7
      end else if (write_end) begin
        program_trigger <= 1'b0; // see RULE8
      end
      if (start_read) begin
        read_trigger <= 1'b1; // see RULE11
      end else if (read_end) begin
        read_trigger <= 1'b0; // see RULE12
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= IDLE_ST;
      timer <= 16'h0000;
    end else begin
      case (state)
        IDLE_ST: begin
          if (start_write) begin
            state <= WRITE_ST;
            timer <= 16'(WRITE_CYCLES - 1); // see RULE21
          end else if (start_read) begin
            state <= READ_ST;
            timer <= 16'(`READ_CYCLES - 1);
          end
        end
        WRITE_ST, READ_ST: begin
          if (timer == 16'h0000) begin
            state <= IDLE_ST;
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        default: begin
          state <= IDLE_ST;
        end
      endcase
    end
  end

  // The array has no reset, as stored contents must survive a reset.
  always_ff @(posedge REF_CLK_I) begin
    if (write_end) begin
      nv_array[nv_address_reg] <= nv_data_reg; // see RULE1
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nv_data_reg <= `NV_RESET_BYTE; // see RULE3
    end else if (read_end) begin
      nv_data_reg <= nv_array[nv_address_reg]; // see RULE12 see RULE13
    end else if (acc.wr && acc.addr == `NV_DATA_OFFSET) begin
      nv_data_reg <= acc.wdata; // see RULE5
    end
  end

  // Set wins over an acknowledge arriving in the same cycle.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      NV_DONE_FLAG_O <= 1'b0;
    end else if (write_end) begin
      NV_DONE_FLAG_O <= 1'b1; // see RULE19
    end else if (IRQ_ACK_I) begin
      NV_DONE_FLAG_O <= 1'b0; // see RULE19
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    if (acc.rd) begin
      if (acc.addr == `NV_ADDRESS_OFFSET) begin
        next_rdata = {2'b00, nv_address_reg}; // see RULE2
        next_hit = 1'b1;
      end else if (acc.addr == `NV_DATA_OFFSET) begin
        next_rdata = nv_data_reg;
        next_hit = 1'b1;
      end else if (acc.addr == `POINTER_ONE_OFFSET) begin
        next_rdata = indirect_pointer_one;
        next_hit = 1'b1;
      end else if (acc.addr == `BANK_SEL_OFFSET) begin
        next_rdata = {7'h00, bank_selector};
        next_hit = 1'b1;
      end else if (ctrl_sel) begin
        next_rdata = ctrl_value; // see RULE17
        next_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SFR_RDATA_O <= 8'h00;
      SFR_HIT_O <= 1'b0;
      NV_BUSY_O <= 1'b0;
    end else begin
      SFR_RDATA_O <= next_rdata;
      SFR_HIT_O <= next_hit;
      NV_BUSY_O <= start_write || start_read || ((state != IDLE_ST) && (timer != 16'h0000));
    end
  end

endmodule
`default_nettype wire

//--- core/nv_access_map.svh
// Register locations, field positions, reset values and timing counts of the nonvolatile access block.
`ifndef NV_ACCESS_MAP_SVH
`define NV_ACCESS_MAP_SVH
`define NV_ADDRESS_OFFSET   8'h1E
`define NV_DATA_OFFSET      8'h1F
`define NV_CONTROL_OFFSET   8'h40
`define INDIRECT_ONE_OFFSET 8'h02
`define POINTER_ONE_OFFSET  8'h03
`define BANK_SEL_OFFSET     8'h04
`define BANK_SEL_BIT        0
`define NV_ADDR_WIDTH       6
`define NV_DEPTH            64
`define CTRL_PROG_PERMIT    3
`define CTRL_PROG_TRIGGER   2
`define CTRL_READ_PERMIT    1
`define CTRL_READ_TRIGGER   0
`define NV_RESET_BYTE       8'h00
`define WRITE_TIME_NS       2000
`define CLK_PERIOD_NS       25
`define WRITE_CYCLES        ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES         2
`endif

//--- core/nv_access_pkg.sv
// Types shared by the nonvolatile access block.
`default_nettype none
package nv_access_pkg;
  typedef enum logic [1:0] {
    IDLE_ST,
    WRITE_ST,
    READ_ST
  } nv_state_type;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_access_type;
endpackage
`default_nettype wire

//--- tb/nv_access_sva.sv
// Port timing checker of the nonvolatile access block.
`default_nettype none
module nv_access_sva #(
  parameter int WRITE_CYCLES = 80
) (
  input wire logic       REF_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       SFR_WR_I,
  input wire logic       SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic       IRQ_ACK_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic       SFR_HIT_O,
  input wire logic       NV_DONE_FLAG_O,
  input wire logic       NV_BUSY_O
);
  // Slack of four cycles covers the start and finish handshakes of a cycle.
  localparam int BUSY_MAX = WRITE_CYCLES + 4;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_addr;
    SFR_RD_I && SFR_ADDR_I == 8'h1E |=> SFR_HIT_O && SFR_RDATA_O[7:6] == 2'h0;
  endproperty
  a_addr: assert property (p_addr) else $error("address read wrong");
  property p_data; SFR_RD_I && SFR_ADDR_I == 8'h1F |=> SFR_HIT_O; endproperty
  a_data: assert property (p_data) else $error("data read missed");
  property p_idle; !SFR_RD_I |=> SFR_RDATA_O == 8'h00 && !SFR_HIT_O; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_ctrl; SFR_RD_I && SFR_ADDR_I == 8'h02 |=> SFR_RDATA_O[7:4] == 4'h0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control upper bits set");
  property p_start; $rose(NV_BUSY_O) |-> $past(SFR_WR_I) || $past(SFR_WR_I, 2); endproperty
  a_start: assert property (p_start) else $error("cycle without trigger");
  property p_len; $rose(NV_BUSY_O) |-> ##[1:BUSY_MAX] !NV_BUSY_O; endproperty
  a_len: assert property (p_len) else $error("cycle too long");
  property p_set; $rose(NV_DONE_FLAG_O) |-> !NV_BUSY_O; endproperty
  a_set: assert property (p_set) else $error("flag before cycle end");
  property p_hold; NV_DONE_FLAG_O && !IRQ_ACK_I |=> NV_DONE_FLAG_O; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_ack; IRQ_ACK_I && !NV_BUSY_O && !$past(NV_BUSY_O) |=> !NV_DONE_FLAG_O; endproperty
  a_ack: assert property (p_ack) else $error("flag not cleared");
endmodule
bind nv_access_ctrl nv_access_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (.REF_CLK_I(REF_CLK_I),
  .RST_N_I(RST_N_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_ADDR_I(SFR_ADDR_I),
  .IRQ_ACK_I(IRQ_ACK_I), .SFR_RDATA_O(SFR_RDATA_O), .SFR_HIT_O(SFR_HIT_O),
  .NV_DONE_FLAG_O(NV_DONE_FLAG_O), .NV_BUSY_O(NV_BUSY_O));
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the nonvolatile access block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       ack = 1'b0;
  logic [7:0] rdata;
  logic       hit;
  logic       done;
  logic       busy;
  logic [7:0] val;
  int         bad_count = 0;
  int         checks = 0;
  always #12.5 clk = ~clk;
  nv_access_ctrl #(.WRITE_CYCLES(4)) dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .SFR_WR_I(wr),
    .SFR_RD_I(rd), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .IRQ_ACK_I(ack),
    .SFR_RDATA_O(rdata), .SFR_HIT_O(hit), .NV_DONE_FLAG_O(done), .NV_BUSY_O(busy));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stands for one cycle only, so it is taken just after the edge that launches it.
    #1 v = rdata;
  endtask
  // Polling is bounded so a trigger that never clears cannot hang the run.
  task automatic settle(input int b);
    int n;
    n = 0;
    val = 8'hFF;
    while (val[b] !== 1'b0 && n < 40) begin
      get(8'h02, val);
      n++;
    end
    chk("trigger", {7'h00, val[b]}, 8'h00);
  endtask
  task automatic nv_write(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    put(8'h1E, a);
    put(8'h1F, d);
    put(8'h02, 8'h08);
    put(8'h02, 8'h0C);
    if (m != 8'h00) put(8'h02, m);
    settle(2);
  endtask
  task automatic nv_read(input logic [7:0] a);
    put(8'h02, 8'h02);
    put(8'h1E, a);
    put(8'h02, 8'h03);
    settle(0);
    get(8'h1F, val);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    get(8'h1F, val);
    chk("data reset", val, 8'h00);
    put(8'h1E, 8'hFF);
    get(8'h1E, val);
    chk("address", val, 8'h3F);
    put(8'h03, 8'h40);
    put(8'h02, 8'h0C);
    put(8'h04, 8'h01);
    get(8'h02, val);
    chk("control bank0", val, 8'h00);
    put(8'h02, 8'h04);
    get(8'h02, val);
    chk("control", val, 8'h00);
    chk("busy", {7'h00, busy}, 8'h00);
    put(8'h02, 8'h01);
    get(8'h1F, val);
    chk("data", val, 8'h00);
    nv_write(8'h00, 8'h5A, 8'h00);
    chk("done", {7'h00, done}, 8'h01);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    #1 chk("done ack", {7'h00, done}, 8'h00);
    nv_write(8'h3F, 8'hC3, 8'h0B);
    get(8'h02, val);
    chk("control busy", val, 8'h0A);
    get(8'h1F, val);
    chk("data busy", val, 8'hC3);
    nv_read(8'h00);
    chk("read low", val, 8'h5A);
    nv_read(8'h3F);
    chk("read high", val, 8'hC3);
    put(8'h1E, 8'h00);
    get(8'h1F, val);
    chk("data kept", val, 8'hC3);
    test_done();
  end
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
